// ### hw/lcg_pkg.sv
/*
 package for the logic cell input gating block: register offsets,
 field positions, widths and reset values.
 assumes: used through lcg_pkg:: scoped names only, nothing imported.
*/
package lcg_pkg;
    // ******************************
    // widths
    // ******************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int SRC_W = 6;
    localparam int NUM_SRC = 64;
    localparam int NUM_CELLS = 4;
    localparam int NUM_GATES = 4;
    localparam int NUM_DATA = 4;
    localparam int INSTANCE_POINTER_W = 3;

    // ******************************
    // register offsets
    // ******************************
    localparam logic [11:0] LOGIC_CELL_CONTROL_OFS = 12'h58c;
    localparam logic [11:0] LOGIC_CELL_POLARITY_OFS = 12'h58d;
    localparam logic [11:0] DATA1_SOURCE_SELECT_OFS = 12'h58e;
    localparam logic [11:0] DATA2_SOURCE_SELECT_OFS = 12'h58f;
    localparam logic [11:0] DATA3_SOURCE_SELECT_OFS = 12'h590;
    localparam logic [11:0] DATA4_SOURCE_SELECT_OFS = 12'h591;
    localparam logic [11:0] GATE1_TERM_SELECT_OFS = 12'h592;
    localparam logic [11:0] GATE2_TERM_SELECT_OFS = 12'h593;
    localparam logic [11:0] GATE3_TERM_SELECT_OFS = 12'h594;
    localparam logic [11:0] GATE4_TERM_SELECT_OFS = 12'h595;
    localparam logic [11:0] CELL_INSTANCE_SELECT_OFS = 12'h596;
    localparam logic [11:0] CELL_OUTPUT_MIRROR_OFS = 12'h597;

    // ******************************
    // fields and reset values
    // ******************************
    localparam logic [5:0] SRC_RESERVED_FIRST = 6'h28;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] POLARITY_RESET = 8'h00;
    localparam logic [5:0] SOURCE_RESET = 6'h00;
    localparam logic [7:0] TERM_RESET = 8'h00;
    localparam logic [2:0] INSTANCE_POINTER_RESET = 3'h0;
    localparam logic [3:0] MIRROR_RESET = 4'h0;
    localparam int POL_GATE_LSB = 0;
    localparam int POL_OUT_BIT = 7;
    localparam int TERM_INV_BIT = 0;
    localparam int TERM_TRUE_BIT = 1;
endpackage

// ### hw/lcg_top.sv
/*
 logic cell input gating: register file, four data selectors, four
 gates with polarity, and the cell output mirror.
 assumes: sources_in and cell_out_in come from logic on clk_sys_in;
 the cell function itself sits outside and consumes gate_out.
*/
`timescale 1ns/100ps
`default_nettype none

module lcg_top (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic clk_en_in,
    input wire logic [11:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [63:0] sources_in,
    input wire logic [3:0] cell_out_in,
    output logic [7:0] rdata_out,
    output logic [3:0] data_out,
    output logic [3:0] gate_out,
    output logic [7:0] control_out,
    output logic [2:0] instance_pointer_out
);
    // ******************************
    // register file
    // ******************************
    logic [7:0] control_q;
    logic [7:0] polarity_q;
    logic [5:0] src_sel_q [4];
    logic [7:0] term_sel_q [4];
    logic [2:0] instance_pointer_q;
    logic [3:0] output_mirror_reg_q;
    logic [3:0] data_q;
    logic [3:0] gate_q;
    logic [7:0] rdata_q;
    logic [3:0] data_d;
    logic [3:0] gate_d;
    logic [7:0] rdata_d;

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            control_q <= lcg_pkg::CONTROL_RESET;
            polarity_q <= lcg_pkg::POLARITY_RESET;
            instance_pointer_q <= lcg_pkg::INSTANCE_POINTER_RESET;
            for (int i = 0; i < 4; i++) begin
                src_sel_q[i] <= lcg_pkg::SOURCE_RESET;
                term_sel_q[i] <= lcg_pkg::TERM_RESET;
            end
        end else if (clk_en_in && wr_in) begin
            unique case (addr_in)
                lcg_pkg::LOGIC_CELL_CONTROL_OFS: control_q <= wdata_in;
                lcg_pkg::LOGIC_CELL_POLARITY_OFS: polarity_q <= wdata_in;
                lcg_pkg::DATA1_SOURCE_SELECT_OFS: src_sel_q[0] <= wdata_in[5:0];
                lcg_pkg::DATA2_SOURCE_SELECT_OFS: src_sel_q[1] <= wdata_in[5:0];
                lcg_pkg::DATA3_SOURCE_SELECT_OFS: src_sel_q[2] <= wdata_in[5:0];
                lcg_pkg::DATA4_SOURCE_SELECT_OFS: src_sel_q[3] <= wdata_in[5:0];
                lcg_pkg::GATE1_TERM_SELECT_OFS: term_sel_q[0] <= wdata_in;
                lcg_pkg::GATE2_TERM_SELECT_OFS: term_sel_q[1] <= wdata_in;
                lcg_pkg::GATE3_TERM_SELECT_OFS: term_sel_q[2] <= wdata_in;
                lcg_pkg::GATE4_TERM_SELECT_OFS: term_sel_q[3] <= wdata_in;
                lcg_pkg::CELL_INSTANCE_SELECT_OFS: begin
                    instance_pointer_q <= wdata_in[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ******************************
    // cell output mirror
    // ******************************
    // hardware owns these bits: writes are ignored since the cells would
    // overwrite them on the next edge anyway
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            output_mirror_reg_q <= lcg_pkg::MIRROR_RESET;
        end else if (clk_en_in) begin
            output_mirror_reg_q <= cell_out_in;
        end
    end

    // ******************************
    // data selectors and gates
    // ******************************
    always_comb begin
        data_d = 4'h0;
        for (int y = 0; y < 4; y++) begin
            if (src_sel_q[y] < lcg_pkg::SRC_RESERVED_FIRST) begin
                data_d[y] = sources_in[src_sel_q[y]];
            end
        end
    end

    always_comb begin
        gate_d = 4'h0;
        for (int g = 0; g < 4; g++) begin
            for (int y = 0; y < 4; y++) begin
                // odd bit true, even bit inverted; OR of terms
                gate_d[g] = gate_d[g]
                    | (term_sel_q[g][2*y+1] & data_d[y])
                    | (term_sel_q[g][2*y] & ~data_d[y]);
            end
            gate_d[g] = gate_d[g] ^ polarity_q[g];
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            data_q <= 4'h0;
            gate_q <= 4'h0;
        end else if (clk_en_in) begin
            data_q <= data_d;
            gate_q <= gate_d;
        end
    end

    // ******************************
    // read path
    // ******************************
    always_comb begin
        unique case (addr_in)
            lcg_pkg::LOGIC_CELL_CONTROL_OFS: rdata_d = control_q;
            lcg_pkg::LOGIC_CELL_POLARITY_OFS: rdata_d = polarity_q;
            lcg_pkg::DATA1_SOURCE_SELECT_OFS: rdata_d = {2'h0, src_sel_q[0]};
            lcg_pkg::DATA2_SOURCE_SELECT_OFS: rdata_d = {2'h0, src_sel_q[1]};
            lcg_pkg::DATA3_SOURCE_SELECT_OFS: rdata_d = {2'h0, src_sel_q[2]};
            lcg_pkg::DATA4_SOURCE_SELECT_OFS: rdata_d = {2'h0, src_sel_q[3]};
            lcg_pkg::GATE1_TERM_SELECT_OFS: rdata_d = term_sel_q[0];
            lcg_pkg::GATE2_TERM_SELECT_OFS: rdata_d = term_sel_q[1];
            lcg_pkg::GATE3_TERM_SELECT_OFS: rdata_d = term_sel_q[2];
            lcg_pkg::GATE4_TERM_SELECT_OFS: rdata_d = term_sel_q[3];
            lcg_pkg::CELL_INSTANCE_SELECT_OFS: begin
                rdata_d = {5'h00, instance_pointer_q};
            end
            lcg_pkg::CELL_OUTPUT_MIRROR_OFS: begin
                rdata_d = {4'h0, output_mirror_reg_q};
            end
            default: rdata_d = 8'h00;
        endcase
    end

    // read data stands for one enabled cycle after the strobe only, and holds while clk_en_in is low
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_q <= 8'h00;
        end else if (clk_en_in) begin
            rdata_q <= rd_in ? rdata_d : 8'h00;
        end
    end

    assign rdata_out = rdata_q;
    assign data_out = data_q;
    assign gate_out = gate_q;
    assign control_out = control_q;
    assign instance_pointer_out = instance_pointer_q;
endmodule

`default_nettype wire

// ### tb/lcg_checker_properties.sv
/* port checker for lcg_top: read port, exports, clock enable.
   assumes: bound to lcg_top; one clock, async active-low reset. */
`timescale 1ns/100ps
`default_nettype none
module lcg_checker (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic clk_en_in,
    input wire logic [11:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [63:0] sources_in,
    input wire logic [3:0] cell_out_in,
    input wire logic [7:0] rdata_out,
    input wire logic [3:0] data_out,
    input wire logic [3:0] gate_out,
    input wire logic [7:0] control_out,
    input wire logic [2:0] instance_pointer_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    // ********************
    // sequences
    // ********************
    sequence ctl_wr_then_rd;
        clk_en_in && wr_in && addr_in == 12'h58c
        ##1 clk_en_in && rd_in && addr_in == 12'h58c;
    endsequence
    // ********************
    // properties
    // ********************
    idle_rdata_a: assert property (clk_en_in && !rd_in |=> rdata_out == 8'h00)
        else $error("read data not idle");
    unmapped_read_a: assert property (clk_en_in && rd_in &&
        (addr_in < 12'h58c || addr_in > 12'h597) |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    select_pad_a: assert property (clk_en_in && rd_in &&
        addr_in inside {[12'h58e:12'h591]} |=> rdata_out[7:6] == 2'h0)
        else $error("selector upper bits set");
    mirror_read_a: assert property (clk_en_in && $past(clk_en_in) && rd_in &&
        addr_in == 12'h597 |=> rdata_out == {4'h0, $past(cell_out_in, 2)})
        else $error("mirror read wrong");
    control_export_a: assert property (clk_en_in && wr_in &&
        addr_in == 12'h58c |=> control_out == $past(wdata_in))
        else $error("control export wrong");
    pointer_export_a: assert property (clk_en_in && wr_in && addr_in ==
        12'h596 |=> instance_pointer_out == $past(wdata_in[2:0]))
        else $error("pointer export wrong");
    control_readback_a: assert property (ctl_wr_then_rd |=>
        rdata_out == $past(wdata_in, 2))
        else $error("control readback wrong");
    enable_freeze_a: assert property (!clk_en_in |=> $stable(data_out) &&
        $stable(gate_out) && $stable(rdata_out))
        else $error("state moved while disabled");
endmodule
bind lcg_top lcg_checker i_chk (.*);
`default_nettype wire

// ### tb/test_logic_cell_input_gating.sv
/* random bench for lcg_top with corner configurations.
   assumes: lcg_top compiled before; checker bound to it. */
`timescale 1ns/100ps
`default_nettype none
module test_logic_cell_input_gating;
    logic clk_sys_in = 1'b0;
    logic nrst_in = 1'b0;
    logic clk_en_in = 1'b1;
    logic [11:0] addr_in = 12'h000;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [63:0] sources_in = 64'h0;
    logic [3:0] cell_out_in = 4'h0;
    logic [7:0] rdata_out, control_out, v;
    logic [3:0] data_out, gate_out, d_exp, g_hold;
    logic [2:0] instance_pointer_out;
    logic [7:0] cfg [12];
    int seed = 42;
    int num_errors = 0;
    int tests_run = 0;
    lcg_top i_dut (.*);
    initial forever #4 clk_sys_in = ~clk_sys_in;
    // ********************
    // tasks
    // ********************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // write strobe is left up so a read may follow with no gap
    task automatic bus_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        wr_in <= 1'b1;
        rd_in <= 1'b0;
        addr_in <= a;
        wdata_in <= d;
    endtask
    task automatic bus_rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1 check(rdata_out, e);
    endtask
    function automatic logic [3:0] gates(input logic [3:0] d);
        logic o;
        for (int g = 0; g < 4; g++) begin
            o = 1'b0;
            for (int y = 0; y < 4; y++)
                o |= cfg[6+g][2*y+1] & d[y] | cfg[6+g][2*y] & ~d[y];
            gates[g] = o ^ cfg[1][g];
        end
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ********************
    // sequence of tests
    // ********************
    initial begin
        repeat (10) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        for (int i = 0; i < 12; i++)
            bus_rd(12'h58c + 12'(i), 8'h00);
        $display("reset values done");
        // pass 0: reserved codes 63 and 40 beside 39, no terms, all inverted
        for (int n = 0; n < 20; n++) begin
            for (int r = 10; r >= 0; r--) begin
                v = 8'($random(seed));
                if (n == 0)
                    v = (r == 1) ? 8'h0f : (r == 2) ? 8'h28 :
                        (r == 3) ? 8'h27 : (r < 6) ? 8'h3f : 8'h00;
                cfg[r] = (r inside {[2:5]}) ? v & 8'h3f :
                    (r == 10) ? v & 8'h07 : v;
                bus_wr(12'h58c + 12'(r), v);
            end
            for (int r = 0; r < 11; r++)
                bus_rd(12'h58c + 12'(r), cfg[r]);
            check(control_out, cfg[0]);
            check({5'h00, instance_pointer_out}, cfg[10]);
            repeat (8) begin
                @(posedge clk_sys_in);
                sources_in <= {$random(seed), $random(seed)};
                cell_out_in <= 4'($random(seed));
                @(posedge clk_sys_in);
                #1;
                for (int y = 0; y < 4; y++)
                    d_exp[y] = cfg[2+y] < 8'h28 && sources_in[cfg[2+y][5:0]];
                check({4'h0, data_out}, {4'h0, d_exp});
                check({4'h0, gate_out}, {4'h0, gates(d_exp)});
            end
            bus_rd(12'h597, {4'h0, cell_out_in});
            $display("configuration pass %0d done", n);
        end
        bus_rd(12'h58b, 8'h00);
        bus_rd(12'h598, 8'h00);
        @(posedge clk_sys_in);
        clk_en_in <= 1'b0;
        sources_in <= ~sources_in;
        // a write offered while disabled must not be taken
        wr_in <= 1'b1;
        addr_in <= 12'h58c;
        wdata_in <= ~cfg[0];
        #1 v = {4'h0, data_out};
        g_hold = gate_out;
        repeat (3) @(posedge clk_sys_in);
        wr_in <= 1'b0;
        #1 check({4'h0, data_out}, v);
        check({4'h0, gate_out}, {4'h0, g_hold});
        check(control_out, cfg[0]);
        @(posedge clk_sys_in);
        clk_en_in <= 1'b1;
        $display("unmapped and freeze done");
        final_report();
    end
    initial begin
        #100000;
        num_errors++;
        final_report();
    end
endmodule
`default_nettype wire
